//--- core/pse_port_ctrl.sv
/*
 * Four-port command and mode logic of a power-sourcing controller,
 * with its two-wire serial register slave.
 * Assumes the analog side gives one-cycle done and fault pulses on
 * clk_sys, and that the serial pins and reset pin are asynchronous.
 */
// Summary of operation
// - Strobe bits act on one, ignore zero, never disturb other bits.
// - Strobe registers read back as zero.
// - Retrigger starts one detect (low nibble) or class (high) in manual.
// - Retrigger in auto or supervised sets the matching enable bit.
// - Switch strobe low nibble sets power flag, high nibble clears it.
// - Switch strobe powers on or off in any mode but shutdown.
// - Overload, inrush or enabled disconnect still power the port down.
// - Power flag refused after fault until overload timer reaches zero.
// - Switch-off also clears events, status and detect-class enables of the port.
// - Clear strobe bits 0-3 reset one port each.
// - Clear strobe bit 4 resets the whole chip, supply flag stays cleared.
// - Clear strobe bit 6 releases interrupt, events kept.
// - After release, interrupt waits until its cause is removed.
// - Clear strobe bit 7 releases interrupt and clears all events.
// - Four modes per port; reset mode follows the strap pin.
// - Host may rewrite mode at any time regardless of strap.
// - Manual ports act only on command and report status.
// - Supervised ports scan repeatedly, power only on host command.
// - Auto ports detect, classify if class enabled, then power on if detection good.
// - Shutdown ports do nothing; status and detect-class enables held zero, events cleared every cycle.
// - Inrush, overload, or enabled disconnect removes power in all modes.
// - Reset pin low or chip reset turns ports off and loads defaults.
// - At reset every mode bit takes the sampled strap level.
// - Manual detect runs one cycle, reports, then idles.
// - Supervised and auto repeat detection at a fixed interval.
`timescale 1ns/1ps
`include "pse_consts.svh"

module pse_port_ctrl
   import pse_pkg::*;
#(
   parameter int unsigned INTERVAL_CYC =
      `PSE_INTERVAL_MS * (`PSE_CLK_HZ / 1000)
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Device pins
   input wire logic rst_pin_n,
   input wire logic auto_strap,
   input wire logic [3:0] addr_pins,
   input wire logic scl,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic int_oe,
   // Measurement and fault side
   input wire logic [3:0] det_done,
   input wire logic [3:0][2:0] det_code,
   input wire logic [3:0] cls_done,
   input wire logic [3:0][2:0] cls_code,
   input wire pse_fault_type faults,
   input wire logic [3:0] overload_hold_timer_zero,
   input wire logic logic_supply_low,
   // Port commands
   output logic [3:0] det_start,
   output logic [3:0] cls_start,
   output logic [3:0] port_power_on
);
   // Pin synchronisers; third stages feed edge detection only
   logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
   logic rpin_s1, rpin_s2, strap_s1, strap_s2;
   logic [3:0] addr_s1, addr_s2;

   always_ff @(posedge clk_sys) begin
      scl_s1 <= scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      rpin_s1 <= rst_pin_n;
      rpin_s2 <= rpin_s1;
      strap_s1 <= auto_strap;
      strap_s2 <= strap_s1;
      addr_s1 <= addr_pins;
      addr_s2 <= addr_s1;
   end

   // Serial slave state
   pse_bus_state_type bus_st_r, bus_after_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r, tx_r, ptr_r, wr_addr_r, wr_data_r;
   logic wr_stb_r, rd_stb_r, nack_r, sda_oe_r, sda_o_r;

   // Port state
   logic [7:0] mode_r, disc_en_r, detcls_en_r;
   logic [7:0] det_evt_r, flt_evt_r;
   logic [3:0][7:0] stat_r;
   logic [3:0] pwr_r, lock_r, busy_r, det_start_r, cls_start_r;
   logic supply_low_r, int_block_r, int_oe_r, tick_r;
   logic [22:0] interval_r;

   wire logic chip_rst;
   wire logic [7:0] rd_data;
   wire pse_strobe_type stb;
   wire logic [3:0] pwr_nxt, lock_nxt, busy_nxt, dstart_nxt, cstart_nxt;
   wire logic [3:0] wipe;
   wire logic [7:0] en_nxt, det_evt_nxt, flt_evt_nxt;
   wire logic [3:0][7:0] stat_nxt;

   // Bus edges and conditions
   wire logic scl_rise = scl_s2 & ~scl_s3;
   wire logic scl_fall = ~scl_s2 & scl_s3;
   wire logic bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   wire logic bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   wire logic cnt_full = (cnt_r == 4'h8);
   wire logic addr_hit = (sh_r[7:1] == {`PSE_BUS_BASE, addr_s2});

   // Strobe decode: a pulse lives only in the cycle the ack begins
   assign stb.retrig = (wr_stb_r && wr_addr_r == `PSE_REG_RETRIG) ?
                       wr_data_r : 8'h00;
   assign stb.switch_p = (wr_stb_r && wr_addr_r == `PSE_REG_SWITCH) ?
                         wr_data_r : 8'h00;
   assign stb.clear = (wr_stb_r && wr_addr_r == `PSE_REG_CLEAR) ?
                      wr_data_r : 8'h00;

   // Reset pin, host reset and chip reset share one path
   assign chip_rst = rst | ~rpin_s2 | stb.clear[`PSE_CLR_CHIP_BIT];

   wire logic wr_mode = wr_stb_r && wr_addr_r == `PSE_REG_MODE;
   wire logic wr_disc = wr_stb_r && wr_addr_r == `PSE_REG_DISC_EN;
   wire logic wr_en = wr_stb_r && wr_addr_r == `PSE_REG_DETCLS_EN;
   wire logic rd_det_cor = rd_stb_r && ptr_r == `PSE_REG_DET_EVT_COR;
   wire logic rd_flt_cor = rd_stb_r && ptr_r == `PSE_REG_FLT_EVT_COR;
   wire logic rd_sup_cor = rd_stb_r && ptr_r == `PSE_REG_SUPPLY_COR;
   wire logic clr_all = stb.clear[`PSE_CLR_ALL_BIT];

   // Interrupt summary
   wire logic [7:0] intr = {5'h00, supply_low_r, |flt_evt_r, |det_evt_r};
   wire logic int_cond = |intr;

   // Read mux; strobe and unmapped offsets answer zero
   wire logic is_stat = (ptr_r[7:2] == `PSE_REG_STAT_BASE);
   wire logic [7:0] sup_byte = {2'h0, supply_low_r, 5'h00};
   assign rd_data =
      (ptr_r == `PSE_REG_INTR) ? intr :
      (ptr_r == `PSE_REG_DET_EVT || ptr_r == `PSE_REG_DET_EVT_COR) ?
         det_evt_r :
      (ptr_r == `PSE_REG_FLT_EVT || ptr_r == `PSE_REG_FLT_EVT_COR) ?
         flt_evt_r :
      (ptr_r == `PSE_REG_SUPPLY || ptr_r == `PSE_REG_SUPPLY_COR) ?
         sup_byte :
      is_stat ? stat_r[ptr_r[1:0]] :
      (ptr_r == `PSE_REG_PWR_STAT) ? {4'h0, pwr_r} :
      (ptr_r == `PSE_REG_PIN_STAT) ? {2'h0, addr_s2, 1'b0, strap_s2} :
      (ptr_r == `PSE_REG_MODE) ? mode_r :
      (ptr_r == `PSE_REG_DISC_EN) ? disc_en_r :
      (ptr_r == `PSE_REG_DETCLS_EN) ? detcls_en_r :
      `PSE_STROBE_READ;

   // Serial slave: sampled bus, sda only ever pulled low
   always_ff @(posedge clk_sys) begin
      if (chip_rst) begin
         bus_st_r <= BUS_IDLE;
         bus_after_r <= BUS_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         tx_r <= 8'h00;
         ptr_r <= 8'h00;
         wr_addr_r <= 8'h00;
         wr_data_r <= 8'h00;
         wr_stb_r <= 1'b0;
         rd_stb_r <= 1'b0;
         nack_r <= 1'b0;
         sda_oe_r <= 1'b0;
         sda_o_r <= 1'b0;
      end else begin
         wr_stb_r <= 1'b0;
         rd_stb_r <= 1'b0;
         sda_o_r <= 1'b0;
         if (bus_start) begin
            bus_st_r <= BUS_ADDR;
            cnt_r <= 4'h0;
            sda_oe_r <= 1'b0;
         end else if (bus_stop) begin
            bus_st_r <= BUS_IDLE;
            sda_oe_r <= 1'b0;
         end else if (scl_rise) begin
            if (bus_st_r == BUS_RACK) begin
               nack_r <= sda_s2;
            end else begin
               sh_r <= {sh_r[6:0], sda_s2};
               cnt_r <= cnt_r + 4'h1;
            end
         end else if (scl_fall) begin
            unique case (bus_st_r)
               BUS_IDLE: begin
                  cnt_r <= 4'h0;
               end
               BUS_ADDR: begin
                  if (cnt_full) begin
                     cnt_r <= 4'h0;
                     bus_st_r <= addr_hit ? BUS_ACK : BUS_IDLE;
                     sda_oe_r <= addr_hit;
                     bus_after_r <= sh_r[0] ? BUS_RDAT : BUS_REG;
                  end
               end
               BUS_REG: begin
                  if (cnt_full) begin
                     cnt_r <= 4'h0;
                     sda_oe_r <= 1'b1;
                     bus_st_r <= BUS_ACK;
                     bus_after_r <= BUS_WDAT;
                     ptr_r <= sh_r;
                  end
               end
               BUS_WDAT: begin
                  if (cnt_full) begin
                     cnt_r <= 4'h0;
                     sda_oe_r <= 1'b1;
                     bus_st_r <= BUS_ACK;
                     bus_after_r <= BUS_WDAT;
                     wr_stb_r <= 1'b1;
                     wr_addr_r <= ptr_r;
                     wr_data_r <= sh_r;
                     ptr_r <= ptr_r + 8'h01;
                  end
               end
               BUS_ACK, BUS_RACK: begin
                  cnt_r <= 4'h0;
                  if (bus_st_r == BUS_RACK && nack_r) begin
                     bus_st_r <= BUS_IDLE;
                     sda_oe_r <= 1'b0;
                  end else if (bus_after_r == BUS_RDAT) begin
                     bus_st_r <= BUS_RDAT;
                     tx_r <= rd_data;
                     sda_oe_r <= ~rd_data[7];
                     rd_stb_r <= 1'b1;
                  end else begin
                     bus_st_r <= bus_after_r;
                     sda_oe_r <= 1'b0;
                  end
               end
               BUS_RDAT: begin
                  if (cnt_full) begin
                     sda_oe_r <= 1'b0;
                     bus_st_r <= BUS_RACK;
                     ptr_r <= ptr_r + 8'h01;
                  end else begin
                     tx_r <= {tx_r[6:0], 1'b0};
                     sda_oe_r <= ~tx_r[6];
                  end
               end
            endcase
         end
      end
   end

   // Shared scan interval for supervised and auto ports
   always_ff @(posedge clk_sys) begin
      if (chip_rst || interval_r == 23'(INTERVAL_CYC - 1)) begin
         interval_r <= 23'h000000;
      end else begin
         interval_r <= interval_r + 23'h000001;
      end
      tick_r <= !chip_rst && interval_r == 23'(INTERVAL_CYC - 1);
   end

   // Per-port command decisions
   genvar p;
   generate
      for (p = 0; p < 4; p++) begin : g_port
         wire pse_mode_type md = pse_mode_type'(mode_r[2*p+1:2*p]);
         wire logic sd = (md == MODE_SHUTDOWN);
         wire logic manual = (md == MODE_MANUAL);
         wire logic scan = (md == MODE_SEMI) || (md == MODE_AUTO);
         wire logic flt = faults.overload[p] | faults.inrush[p];
         wire logic disc = faults.disconnect[p] &
                           (disc_en_r[p] | disc_en_r[p+4]);
         wire logic good = det_done[p] && det_code[p] == `PSE_DET_GOOD;
         wire logic cls_next = scan & busy_r[p] & good & detcls_en_r[p+4];
         wire logic det_ok = (stat_r[p][2:0] == `PSE_DET_GOOD);
         wire logic auto_on = (md == MODE_AUTO) & busy_r[p] &
                              ((good & ~detcls_en_r[p+4]) |
                               (cls_done[p] & det_ok));
         wire logic scan_go = scan & tick_r & detcls_en_r[p] &
                              ~busy_r[p] & ~pwr_r[p];
         wire logic on_req = (stb.switch_p[p] | auto_on) &
                             ~sd & ~lock_r[p];
         wire logic off_req = stb.switch_p[p+4] | stb.clear[p] | sd |
                              flt | disc;

         assign wipe[p] = stb.switch_p[p+4] | stb.clear[p] | sd;
         assign pwr_nxt[p] = ~off_req & (pwr_r[p] | on_req);
         assign lock_nxt[p] = (lock_r[p] & ~overload_hold_timer_zero[p]) |
                              (flt & pwr_r[p]);
         assign dstart_nxt[p] = ~pwr_r[p] &
            ((manual & stb.retrig[p]) | scan_go);
         assign cstart_nxt[p] = ~pwr_r[p] &
            ((manual & stb.retrig[p+4]) | cls_next);
         assign busy_nxt[p] = scan & ~wipe[p] &
            (scan_go | cls_next |
             (busy_r[p] & ~det_done[p] & ~cls_done[p]));
         // Write, then host retrigger sets, then port wipe wins
         assign en_nxt[p] = ~wipe[p] & ((wr_en ? wr_data_r[p] :
            detcls_en_r[p]) | (scan & stb.retrig[p]));
         assign en_nxt[p+4] = ~wipe[p] & ((wr_en ? wr_data_r[p+4] :
            detcls_en_r[p+4]) | (scan & stb.retrig[p+4]));
         assign stat_nxt[p] = wipe[p] ? 8'h00 :
            {1'b0, cls_done[p] ? cls_code[p] : stat_r[p][6:4],
             1'b0, det_done[p] ? det_code[p] : stat_r[p][2:0]};
         // New event beats any clear in the same cycle
         assign det_evt_nxt[p] = det_done[p] |
            (det_evt_r[p] & ~wipe[p] & ~clr_all & ~rd_det_cor);
         assign det_evt_nxt[p+4] = faults.disconnect[p] |
            (det_evt_r[p+4] & ~wipe[p] & ~clr_all & ~rd_det_cor);
         assign flt_evt_nxt[p] = faults.overload[p] |
            (flt_evt_r[p] & ~wipe[p] & ~clr_all & ~rd_flt_cor);
         assign flt_evt_nxt[p+4] = faults.inrush[p] |
            (flt_evt_r[p+4] & ~wipe[p] & ~clr_all & ~rd_flt_cor);
      end
   endgenerate

   // Host-written configuration
   always_ff @(posedge clk_sys) begin
      if (chip_rst) begin
         mode_r <= {8{strap_s2}};
         disc_en_r <= 8'h00;
         detcls_en_r <= 8'h00;
      end else begin
         mode_r <= wr_mode ? wr_data_r : mode_r;
         disc_en_r <= wr_disc ? wr_data_r : disc_en_r;
         detcls_en_r <= en_nxt;
      end
   end

   // Port state and commands
   always_ff @(posedge clk_sys) begin
      if (chip_rst) begin
         pwr_r <= 4'h0;
         lock_r <= 4'h0;
         busy_r <= 4'h0;
         det_start_r <= 4'h0;
         cls_start_r <= 4'h0;
         stat_r <= '0;
         det_evt_r <= 8'h00;
         flt_evt_r <= 8'h00;
      end else begin
         pwr_r <= pwr_nxt;
         lock_r <= lock_nxt;
         busy_r <= busy_nxt;
         det_start_r <= dstart_nxt;
         cls_start_r <= cstart_nxt;
         stat_r <= stat_nxt;
         det_evt_r <= det_evt_nxt;
         flt_evt_r <= flt_evt_nxt;
      end
   end

   // Supply flag and interrupt pin
   always_ff @(posedge clk_sys) begin
      if (chip_rst) begin
         supply_low_r <= 1'b0;
         int_block_r <= 1'b0;
         int_oe_r <= 1'b0;
      end else begin
         supply_low_r <= logic_supply_low |
            (supply_low_r & ~clr_all & ~rd_sup_cor);
         int_block_r <= int_cond & ~clr_all &
            (int_block_r | stb.clear[`PSE_CLR_REL_BIT]);
         int_oe_r <= int_cond & ~int_block_r & ~clr_all &
            ~stb.clear[`PSE_CLR_REL_BIT];
      end
   end

   assign sda_o = sda_o_r;
   assign sda_oe = sda_oe_r;
   assign int_oe = int_oe_r;
   assign det_start = det_start_r;
   assign cls_start = cls_start_r;
   assign port_power_on = pwr_r;
endmodule

//--- core/pse_consts.svh
/*
 * Register offsets, field positions, reset values and timing counts
 * of the port command and mode block.
 * Assumes inclusion by bare name from the top module.
 */
`ifndef PSE_CONSTS_SVH
`define PSE_CONSTS_SVH

`define PSE_REG_INTR 8'h00
`define PSE_REG_DET_EVT 8'h04
`define PSE_REG_DET_EVT_COR 8'h05
`define PSE_REG_FLT_EVT 8'h06
`define PSE_REG_FLT_EVT_COR 8'h07
`define PSE_REG_SUPPLY 8'h0a
`define PSE_REG_SUPPLY_COR 8'h0b
`define PSE_REG_STAT_BASE 6'h03
`define PSE_REG_PWR_STAT 8'h10
`define PSE_REG_PIN_STAT 8'h11
`define PSE_REG_MODE 8'h12
`define PSE_REG_DISC_EN 8'h13
`define PSE_REG_DETCLS_EN 8'h14
`define PSE_REG_RETRIG 8'h18
`define PSE_REG_SWITCH 8'h19
`define PSE_REG_CLEAR 8'h1a

`define PSE_CLR_CHIP_BIT 4
`define PSE_CLR_REL_BIT 6
`define PSE_CLR_ALL_BIT 7
`define PSE_SUPPLY_LOW_BIT 5

`define PSE_STROBE_READ 8'h00
`define PSE_DET_GOOD 3'h4
`define PSE_BUS_BASE 3'h2

`define PSE_CLK_HZ 20000000
`define PSE_INTERVAL_MS 320

`endif

//--- core/pse_pkg.sv
/*
 * Types shared by the port command and mode block.
 * Assumes the constants header is on the include path.
 */
package pse_pkg;
   // Order matters: strap low gives all zero, strap high all ones
   typedef enum logic [1:0] {
      MODE_SHUTDOWN,
      MODE_MANUAL,
      MODE_SEMI,
      MODE_AUTO
   } pse_mode_type;

   typedef enum logic [2:0] {
      BUS_IDLE,
      BUS_ADDR,
      BUS_REG,
      BUS_WDAT,
      BUS_ACK,
      BUS_RDAT,
      BUS_RACK
   } pse_bus_state_type;

   typedef struct packed {
      logic [7:0] retrig;
      logic [7:0] switch_p;
      logic [7:0] clear;
   } pse_strobe_type;

   typedef struct packed {
      logic [3:0] overload;
      logic [3:0] inrush;
      logic [3:0] disconnect;
   } pse_fault_type;
endpackage

//--- bench/pse_port_ctrl_monitor.sv
/*
 * Concurrent checks on the ports of the port command block.
 * Assumes pse_pkg is compiled first; bound to the block's top module.
 */
`timescale 1ns/1ps
module pse_port_ctrl_monitor
   import pse_pkg::*;
(
   // Clock and resets
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic rst_pin_n,
   // Port side inputs
   input wire logic [3:0] det_done,
   input wire pse_fault_type faults,
   input wire logic [3:0] overload_hold_timer_zero,
   input wire logic logic_supply_low,
   // Watched outputs
   input wire logic sda_oe,
   input wire logic int_oe,
   input wire logic [3:0] det_start,
   input wire logic [3:0] cls_start,
   input wire logic [3:0] port_power_on
);
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   logic [3:0] hit;
   logic [3:0] lock_r;
   logic seen_r;
   assign hit = faults.overload | faults.inrush;
   // Mirrors the fault lock; a fault on a powered port sets it
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lock_r <= 4'h0;
         seen_r <= 1'b0;
      end else begin
         lock_r <= (lock_r & ~overload_hold_timer_zero) |
            (hit & port_power_on);
         seen_r <= seen_r | (|det_done) | (|faults) | logic_supply_low;
      end
   end
   det_pulse_a: assert property ((det_start & $past(det_start)) == 4'h0)
      else $error("detect start held past one cycle");
   cls_pulse_a: assert property ((cls_start & $past(cls_start)) == 4'h0)
      else $error("class start held past one cycle");
   reset_clear_a: assert property ($fell(rst) |-> port_power_on == 4'h0 &&
      !int_oe && !sda_oe && det_start == 4'h0)
      else $error("outputs not cleared by reset");
   pin_reset_a: assert property (!rst_pin_n [*3] |=>
      port_power_on == 4'h0 && !int_oe && !sda_oe)
      else $error("reset pin did not clear outputs");
   fault_off_a: assert property (hit != 4'h0 |=>
      (port_power_on & $past(hit)) == 4'h0)
      else $error("port kept power after fault");
   idle_powered_a: assert property (((det_start | cls_start) &
      port_power_on & $past(port_power_on)) == 4'h0)
      else $error("probe started on powered port");
   power_lock_a: assert property ((port_power_on &
      ~$past(port_power_on) & $past(lock_r)) == 4'h0)
      else $error("power set while fault lock held");
   int_cause_a: assert property (int_oe |-> seen_r)
      else $error("interrupt without any event");
   power_up_c: cover property ($rose(|port_power_on));
   start_c: cover property (det_start != 4'h0);
   int_c: cover property ($rose(int_oe));
endmodule
bind pse_port_ctrl pse_port_ctrl_monitor i_pse_port_ctrl_monitor (
   .clk_sys, .rst, .rst_pin_n, .det_done, .faults,
   .overload_hold_timer_zero, .logic_supply_low, .sda_oe, .int_oe,
   .det_start, .cls_start, .port_power_on);

//--- bench/pse_host_model.sv
/*
 * Serial host model: register writes and reads, 8 clocks per bit.
 * Assumes the bench builds the open-drain data line with a pull-up.
 */
`timescale 1ns/1ps
module pse_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h25
) (
   // Bench clock
   input wire logic clk_sys,
   // Serial pins
   input wire logic sda_line,
   output logic scl,
   output logic sda_pull
);
   int nack_count = 0;
   // Clock idles high outside frames
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic quarter();
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   task automatic bit_io(input logic pull, output logic seen);
      sda_pull = pull;
      quarter();
      scl = 1'b1;
      quarter();
      seen = sda_line;
      quarter();
      scl = 1'b0;
      quarter();
   endtask
   task automatic start();
      sda_pull = 1'b0;
      quarter();
      scl = 1'b1;
      quarter();
      sda_pull = 1'b1;
      quarter();
      scl = 1'b0;
      quarter();
   endtask
   task automatic stop();
      sda_pull = 1'b1;
      quarter();
      scl = 1'b1;
      quarter();
      sda_pull = 1'b0;
      quarter();
   endtask
   // Ninth bit is always released: acknowledge in, or our NACK out
   task automatic byte_io(input logic [7:0] tx, input logic chk,
      output logic [7:0] rx);
      logic ack;
      for (int i = 7; i >= 0; i--) begin
         bit_io(~tx[i], rx[i]);
      end
      bit_io(1'b0, ack);
      if (chk && ack) begin
         nack_count++;
      end
   endtask
   task automatic wr(input logic [7:0] ra, input logic [7:0] data);
      logic [7:0] junk;
      start();
      byte_io({DEV_ADDR, 1'b0}, 1'b1, junk);
      byte_io(ra, 1'b1, junk);
      byte_io(data, 1'b1, junk);
      stop();
   endtask
   task automatic rd(input logic [7:0] ra, output logic [7:0] data);
      logic [7:0] junk;
      start();
      byte_io({DEV_ADDR, 1'b0}, 1'b1, junk);
      byte_io(ra, 1'b1, junk);
      start();
      byte_io({DEV_ADDR, 1'b1}, 1'b1, junk);
      byte_io(8'hff, 1'b0, data);
      stop();
   endtask
endmodule

//--- bench/pse_port_ctrl_tb.sv
/*
 * Self-checking bench of the port command block with a serial host.
 * Assumes package, design, checker and host model compiled before.
 */
`timescale 1ns/1ps
module pse_port_ctrl_tb
   import pse_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic rst_pin_n = 1'b1;
   logic auto_strap = 1'b1;
   logic [3:0] tz = 4'h0;
   logic [3:0] det_done = 4'h0;
   logic [3:0][2:0] det_code = '0;
   pse_fault_type flt = '0;
   logic [3:0] cls_done = 4'h0;
   logic [3:0][2:0] cls_code = '0;
   logic logic_supply_low = 1'b0;
   logic sda_o;
   wire logic scl;
   wire logic sda_pull;
   logic sda_oe;
   logic int_oe;
   logic [3:0] det_start;
   logic [3:0] cls_start;
   logic [3:0] port_power_on;
   logic [3:0] pwr_prev;
   logic [7:0] q_start[$];
   logic [7:0] q_pwr[$];
   logic free_run = 1'b0;
   logic [7:0] rd_data;
   logic [7:0] rnd;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   wire logic sda_line = ~(sda_pull | (sda_oe & ~sda_o));
   always #25 clk_sys = ~clk_sys;
   // Short scan interval keeps the run brief
   pse_port_ctrl #(.INTERVAL_CYC(64)) i_pse_port_ctrl (
      .clk_sys, .rst, .rst_pin_n, .auto_strap, .addr_pins(4'h5), .scl,
      .sda_i(sda_line), .sda_o, .sda_oe, .int_oe, .det_done, .det_code,
      .cls_done, .cls_code, .faults(flt),
      .overload_hold_timer_zero(tz), .logic_supply_low, .det_start,
      .cls_start, .port_power_on);
   pse_host_model i_pse_host_model (.clk_sys, .sda_line, .scl, .sda_pull);
   task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      i_pse_host_model.rd(a, rd_data);
      cmp(exp, rd_data);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic summarize();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Start pulses and power changes are taken against the notes in order
   always @(posedge clk_sys) begin
      if (rst) begin
         pwr_prev = 4'h0;
      end else begin
         if ((det_start | cls_start) != 4'h0) begin
            if (q_start.size() > 0) begin
               cmp(q_start.pop_front(), {cls_start, det_start});
            end else if (!free_run) begin
               cmp(8'h00, {cls_start, det_start});
            end
         end
         if (port_power_on !== pwr_prev) begin
            cmp((q_pwr.size() > 0) ? q_pwr.pop_front() : 8'hee,
               {4'h0, port_power_on});
            pwr_prev = port_power_on;
         end
      end
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         err_total++;
         $display("BAD %0t timeout", $time);
         summarize();
      end
   end
   initial begin
      void'($urandom(32'hb496));
      tick(6);
      rst = 1'b0;
      tick(2);
      rd_chk(8'h12, 8'hff);
      for (int a = 24; a <= 26; a++) begin
         rd_chk(8'(a), 8'h00);
      end
      rd_chk(8'h1f, 8'h00);
      i_pse_host_model.wr(8'h12, 8'h55);
      rd_chk(8'h12, 8'h55);
      q_start.push_back(8'h05);
      i_pse_host_model.wr(8'h18, 8'h05);
      q_start.push_back(8'h90);
      i_pse_host_model.wr(8'h18, 8'h90);
      rd_chk(8'h14, 8'h00);
      q_pwr.push_back(8'h0f);
      i_pse_host_model.wr(8'h19, 8'h0f);
      q_pwr.push_back(8'h0d);
      flt.overload = 4'h2;
      tick(1);
      flt = '0;
      i_pse_host_model.wr(8'h19, 8'h02);
      cmp(8'h0d, {4'h0, port_power_on});
      tz = 4'hf;
      tick(2);
      q_pwr.push_back(8'h0f);
      i_pse_host_model.wr(8'h19, 8'h02);
      i_pse_host_model.wr(8'h19, 8'h00);
      q_pwr.push_back(8'h0c);
      i_pse_host_model.wr(8'h19, 8'h30);
      q_pwr.push_back(8'h08);
      i_pse_host_model.wr(8'h1a, 8'h04);
      q_pwr.push_back(8'h00);
      i_pse_host_model.wr(8'h12, 8'h15);
      i_pse_host_model.wr(8'h19, 8'h08);
      cmp(8'h00, {4'h0, port_power_on});
      free_run = 1'b1;
      i_pse_host_model.wr(8'h12, 8'hff);
      i_pse_host_model.wr(8'h18, 8'h01);
      rd_chk(8'h14, 8'h01);
      q_pwr.push_back(8'h01);
      det_code[0] = 3'h4;
      det_done = 4'h1;
      tick(1);
      det_done = 4'h0;
      tick(4);
      cmp(8'h01, {7'h0, int_oe});
      rd_chk(8'h0c, 8'h04);
      i_pse_host_model.wr(8'h1a, 8'h40);
      cmp(8'h00, {7'h0, int_oe});
      rd_chk(8'h04, 8'h01);
      cmp(8'h00, {7'h0, int_oe});
      i_pse_host_model.wr(8'h1a, 8'h80);
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h00, 8'h00);
      q_pwr.push_back(8'h00);
      i_pse_host_model.wr(8'h19, 8'h10);
      rd_chk(8'h14, 8'h00);
      rd_chk(8'h0c, 8'h00);
      i_pse_host_model.wr(8'h14, 8'h11);
      rd_chk(8'h14, 8'h11);
      cls_code[0] = 3'h3;
      det_done = 4'h1;
      tick(1);
      det_done = 4'h0;
      tick(3);
      cmp(8'h00, {4'h0, port_power_on});
      q_pwr.push_back(8'h01);
      cls_done = 4'h1;
      tick(1);
      cls_done = 4'h0;
      tick(3);
      rd_chk(8'h0c, 8'h34);
      q_pwr.push_back(8'h00);
      i_pse_host_model.wr(8'h19, 8'h10);
      q_pwr.push_back(8'h01);
      i_pse_host_model.wr(8'h19, 8'h01);
      i_pse_host_model.wr(8'h13, 8'h01);
      q_pwr.push_back(8'h00);
      flt.disconnect = 4'h1;
      tick(1);
      flt = '0;
      for (int i = 0; i < 4; i++) begin
         rnd = 8'($urandom());
         i_pse_host_model.wr(8'h13, rnd);
         rd_chk(8'h13, rnd);
      end
      cmp(8'h00, 8'(i_pse_host_model.nack_count));
      logic_supply_low = 1'b1;
      tick(1);
      logic_supply_low = 1'b0;
      rd_chk(8'h0a, 8'h20);
      auto_strap = 1'b0;
      q_pwr.push_back(8'h01);
      i_pse_host_model.wr(8'h19, 8'h01);
      q_pwr.push_back(8'h00);
      i_pse_host_model.wr(8'h1a, 8'h10);
      rd_chk(8'h12, 8'h00);
      rd_chk(8'h13, 8'h00);
      rd_chk(8'h0a, 8'h00);
      auto_strap = 1'b1;
      i_pse_host_model.wr(8'h12, 8'h55);
      q_pwr.push_back(8'h01);
      i_pse_host_model.wr(8'h19, 8'h01);
      q_pwr.push_back(8'h00);
      rst_pin_n = 1'b0;
      tick(4);
      rst_pin_n = 1'b1;
      tick(4);
      rd_chk(8'h12, 8'hff);
      cmp(8'h00, 8'(q_pwr.size() + q_start.size()));
      summarize();
   end
endmodule
